// ---- rtl/src_reset_clock_ctrl.sv ----
// downstream reset, transmit lane mapping and reference clock buffer control
`timescale 1ns/1ps
module src_reset_clock_ctrl #(
  parameter logic [src_pkg::PLUG_CNT_W-1:0] PLUG_RESET_CYCLES = src_pkg::PLUG_RESET_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // system reset and straps
  input wire logic system_reset_n,
  input wire logic clock_buffer_power_down,
  // slot presence, low when a device sits in the slot
  input wire logic [2:1] device_present_n,
  // reference clock buffer
  input wire logic buffer_refclk_in_pos,
  input wire logic buffer_refclk_in_neg,
  output logic [src_pkg::REFCLK_OUTS-1:0] buffered_refclk_out_pos,
  output logic [src_pkg::REFCLK_OUTS-1:0] buffered_refclk_out_neg,
  output logic clock_buffer_enabled,
  // transmit lanes
  input wire src_pkg::src_tx_ports_t tx_port_data,
  output logic [src_pkg::TX_LANES-1:0] tx_lane_pos,
  output logic [src_pkg::TX_LANES-1:0] tx_lane_neg,
  // downstream resets and sticky flags
  output logic [2:1] downstream_reset_n,
  output logic [2:1] sticky_plug_seen
);

  logic [src_pkg::PIN_W-1:0] pin_sync;
  logic sys_reset_active;
  logic buf_pd;
  logic [2:1] present;
  logic [2:1] present_prev;
  logic [2:1] plug_event;
  logic refclk_pos;
  logic refclk_neg;
  src_pkg::src_port_state_t port_state [2:1];
  src_pkg::src_port_state_t next_port_state [2:1];
  logic [src_pkg::PLUG_CNT_W-1:0] plug_cnt [2:1];
  logic [src_pkg::PLUG_CNT_W-1:0] next_plug_cnt [2:1];

  // picks the port lane that feeds each transmit lane
  function automatic logic [src_pkg::TX_LANES-1:0] lane_map(input src_pkg::src_tx_ports_t ports,
                                                          input logic take_neg);
    logic [src_pkg::TX_LANES-1:0] lanes;
    lanes = src_pkg::TX_IDLE;
    lanes[src_pkg::LANE_UP0] = take_neg ? ports.up0.neg : ports.up0.pos;
    lanes[src_pkg::LANE_UP1] = take_neg ? ports.up1.neg : ports.up1.pos;
    lanes[src_pkg::LANE_DN1] = take_neg ? ports.dn1.neg : ports.dn1.pos;
    lanes[src_pkg::LANE_DN2] = take_neg ? ports.dn2.neg : ports.dn2.pos;
    return lanes;
  endfunction

  // last counted cycle of a plug reset hold
  function automatic logic hold_done(input logic [src_pkg::PLUG_CNT_W-1:0] cnt);
    return cnt >= PLUG_RESET_CYCLES - 22'h000001;
  endfunction

  // all pins but the transmit port data pass two flip-flops
  src_sync2 #(
    .WIDTH(src_pkg::PIN_W),
    .RESET_VALUE(src_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({system_reset_n,
               clock_buffer_power_down,
               device_present_n[2],
               device_present_n[1],
               buffer_refclk_in_pos,
               buffer_refclk_in_neg}),
    .sync_out(pin_sync)
  );

  // synchronised pin levels
  assign sys_reset_active = !pin_sync[src_pkg::PIN_SYS_RST_N];
  assign buf_pd = pin_sync[src_pkg::PIN_BUF_PD];
  assign present[2] = !pin_sync[src_pkg::PIN_PRESENT_N_HI];
  assign present[1] = !pin_sync[src_pkg::PIN_PRESENT_N_LO];
  assign refclk_pos = pin_sync[src_pkg::PIN_REFCLK_POS];
  assign refclk_neg = pin_sync[src_pkg::PIN_REFCLK_NEG];

  // newly present device, ignored while the system is in reset
  assign plug_event = present & ~present_prev & {2{!sys_reset_active}};

  // presence history, reloaded during system reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      present_prev <= 2'h0;
    end else begin
      present_prev <= present;
    end
  end

  // per-port plug sequencing
  always_comb begin
    for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
      next_port_state[p] = port_state[p];
      next_plug_cnt[p] = plug_cnt[p];
      if (sys_reset_active) begin
        // a seated device gets only the system reset
        next_port_state[p] = present[p] ? src_pkg::PS_RUN : src_pkg::PS_EMPTY;
        next_plug_cnt[p] = src_pkg::PLUG_CNT_RESET;
      end else begin
        case (port_state[p])
          src_pkg::PS_EMPTY: begin
            if (plug_event[p]) begin
              next_port_state[p] = src_pkg::PS_PLUG_RESET;
              next_plug_cnt[p] = src_pkg::PLUG_CNT_RESET;
            end
          end
          src_pkg::PS_PLUG_RESET: begin
            if (!present[p]) begin
              next_port_state[p] = src_pkg::PS_EMPTY;
            end else if (hold_done(plug_cnt[p])) begin
              next_port_state[p] = src_pkg::PS_RUN;
            end else begin
              next_plug_cnt[p] = plug_cnt[p] + 22'h000001;
            end
          end
          src_pkg::PS_RUN: begin
            if (!present[p]) begin
              next_port_state[p] = src_pkg::PS_EMPTY;
            end
          end
          default: begin
            next_port_state[p] = src_pkg::PS_EMPTY;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
        port_state[p] <= src_pkg::PS_EMPTY;
      end
    end else begin
      for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
        port_state[p] <= next_port_state[p];
      end
    end
  end

  // plug reset hold counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
        plug_cnt[p] <= src_pkg::PLUG_CNT_RESET;
      end
    end else begin
      for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
        plug_cnt[p] <= next_plug_cnt[p];
      end
    end
  end

  // one reset per downstream port, bit x for port x
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      downstream_reset_n <= src_pkg::DN_RESET_ASSERTED;
    end else begin
      for (int p = src_pkg::DN_PORT_LO; p <= src_pkg::DN_PORT_HI; p++) begin
        downstream_reset_n[p] <= !(sys_reset_active || next_port_state[p] == src_pkg::PS_PLUG_RESET);
      end
    end
  end

  // sticky plug flags survive system reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sticky_plug_seen <= src_pkg::STICKY_RESET;
    end else begin
      sticky_plug_seen <= sticky_plug_seen | plug_event;
    end
  end

  // transmit lane mapping, idle during system reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_lane_pos <= src_pkg::TX_IDLE;
      tx_lane_neg <= src_pkg::TX_IDLE;
    end else if (sys_reset_active) begin
      tx_lane_pos <= src_pkg::TX_IDLE;
      tx_lane_neg <= src_pkg::TX_IDLE;
    end else begin
      tx_lane_pos <= lane_map(tx_port_data, 1'b0);
      tx_lane_neg <= lane_map(tx_port_data, 1'b1);
    end
  end

  // clock buffer enable follows the power-down strap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_buffer_enabled <= 1'b0;
    end else begin
      clock_buffer_enabled <= !buf_pd;
    end
  end

  // three buffered copies of the reference clock, both legs low when off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffered_refclk_out_pos <= src_pkg::REFCLK_OFF;
      buffered_refclk_out_neg <= src_pkg::REFCLK_OFF;
    end else if (buf_pd) begin
      buffered_refclk_out_pos <= src_pkg::REFCLK_OFF;
      buffered_refclk_out_neg <= src_pkg::REFCLK_OFF;
    end else begin
      buffered_refclk_out_pos <= {src_pkg::REFCLK_OUTS{refclk_pos}};
      buffered_refclk_out_neg <= {src_pkg::REFCLK_OUTS{refclk_neg}};
    end
  end

endmodule

// ---- rtl/src_pkg.sv ----
// shared constants and types for the switch reset and clock buffer control block
package src_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PLUG_RESET_TIME_NS = 100000000;
  localparam int unsigned PLUG_RESET_CYCLES_INT = PLUG_RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PLUG_CNT_W = 22;
  localparam logic [PLUG_CNT_W-1:0] PLUG_RESET_CYCLES = PLUG_RESET_CYCLES_INT[PLUG_CNT_W-1:0];
  localparam logic [PLUG_CNT_W-1:0] PLUG_CNT_RESET = 22'h000000;

  // lane and port counts
  localparam int unsigned TX_LANES = 4;
  localparam int unsigned REFCLK_OUTS = 3;
  localparam int unsigned DN_PORT_LO = 1;
  localparam int unsigned DN_PORT_HI = 2;

  // transmit lane index of each port lane
  localparam int unsigned LANE_UP0 = 0;
  localparam int unsigned LANE_DN1 = 1;
  localparam int unsigned LANE_DN2 = 2;
  localparam int unsigned LANE_UP1 = 3;

  // pin synchroniser bit layout
  localparam int unsigned PIN_W = 6;
  localparam int unsigned PIN_SYS_RST_N = 5;
  localparam int unsigned PIN_BUF_PD = 4;
  localparam int unsigned PIN_PRESENT_N_HI = 3;
  localparam int unsigned PIN_PRESENT_N_LO = 2;
  localparam int unsigned PIN_REFCLK_POS = 1;
  localparam int unsigned PIN_REFCLK_NEG = 0;
  // system reset asserted, buffer enabled, both slots empty, clock low
  localparam logic [PIN_W-1:0] PIN_RESET = 6'h0C;

  // output reset values
  localparam logic [TX_LANES-1:0] TX_IDLE = 4'h0;
  localparam logic [REFCLK_OUTS-1:0] REFCLK_OFF = 3'h0;
  localparam logic [1:0] DN_RESET_ASSERTED = 2'h0;
  localparam logic [1:0] STICKY_RESET = 2'h0;

  typedef struct packed {
    logic pos;
    logic neg;
  } src_diff_t;

  // transmit data of each port lane before lane mapping
  typedef struct packed {
    src_diff_t dn2;
    src_diff_t dn1;
    src_diff_t up1;
    src_diff_t up0;
  } src_tx_ports_t;

  typedef enum logic [1:0] {
    PS_EMPTY,
    PS_PLUG_RESET,
    PS_RUN
  } src_port_state_t;

endpackage

// ---- rtl/src_sync2.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module src_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous pins
  input wire logic [WIDTH-1:0] async_in,
  // synchronised levels
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- verif/src_properties.sv ----
// concurrent checks on the reset, lane and clock buffer outputs
`timescale 1ns/1ps
module src_properties #(
  parameter logic [src_pkg::PLUG_CNT_W-1:0] PLUG_RESET_CYCLES = src_pkg::PLUG_RESET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic system_reset_n,
  input wire logic clock_buffer_power_down,
  input wire logic [2:1] device_present_n,
  input wire logic buffer_refclk_in_pos,
  input wire logic buffer_refclk_in_neg,
  input wire src_pkg::src_tx_ports_t tx_port_data,
  // outputs
  input wire logic [src_pkg::REFCLK_OUTS-1:0] buffered_refclk_out_pos,
  input wire logic [src_pkg::REFCLK_OUTS-1:0] buffered_refclk_out_neg,
  input wire logic clock_buffer_enabled,
  input wire logic [src_pkg::TX_LANES-1:0] tx_lane_pos,
  input wire logic [src_pkg::TX_LANES-1:0] tx_lane_neg,
  input wire logic [2:1] downstream_reset_n,
  input wire logic [2:1] sticky_plug_seen
);
  logic [2:0] up_cnt;
  src_pkg::src_tx_ports_t d_q;
  logic settled;
  assign settled = up_cnt == 3'h7;
  // edges since release, so history checks skip reset leftovers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      d_q <= '0;
    end else begin
      d_q <= tx_port_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_sysrst_clears_out: assert property ((!system_reset_n)[*4] |->
    downstream_reset_n == 2'h0 && tx_lane_pos == 4'h0 && tx_lane_neg == 4'h0) else $error("system reset not applied");
  a_lane_map_order: assert property ((settled && system_reset_n)[*5] |->
    tx_lane_pos == {d_q.up1.pos, d_q.dn2.pos, d_q.dn1.pos, d_q.up0.pos} &&
    tx_lane_neg == {d_q.up1.neg, d_q.dn2.neg, d_q.dn1.neg, d_q.up0.neg}) else $error("lane mapping wrong");
  a_buf_power_off: assert property (clock_buffer_power_down[*4] |-> !clock_buffer_enabled &&
    buffered_refclk_out_pos == 3'h0 && buffered_refclk_out_neg == 3'h0) else $error("buffer not off");
  a_buf_power_on: assert property ((settled && !clock_buffer_power_down)[*4] |-> clock_buffer_enabled)
    else $error("buffer not on");
  a_refclk_copy_all: assert property (settled && clock_buffer_enabled |->
    buffered_refclk_out_pos == {3{$past(buffer_refclk_in_pos, 3)}} &&
    buffered_refclk_out_neg == {3{$past(buffer_refclk_in_neg, 3)}}) else $error("refclk not copied");
  a_plug_starts_reset: assert property ((settled && system_reset_n)[*4] ##1
    ($fell(device_present_n[1]) && system_reset_n) |-> ##[2:4] !downstream_reset_n[1])
    else $error("plug reset missing");
  a_sticky_low_one: assert property ($rose(sticky_plug_seen[1]) |-> !downstream_reset_n[1])
    else $error("port 1 flag without reset");
  a_sticky_low_two: assert property ($rose(sticky_plug_seen[2]) |-> !downstream_reset_n[2])
    else $error("port 2 flag without reset");
  a_sticky_kept: assert property (!$fell(sticky_plug_seen[1]) && !$fell(sticky_plug_seen[2]))
    else $error("sticky flag lost");
  c_plug_two: cover property ($rose(sticky_plug_seen[2]));
  c_buf_off: cover property ($fell(clock_buffer_enabled));
  c_release: cover property ($rose(downstream_reset_n[1]));
endmodule
bind src_reset_clock_ctrl src_properties #(.PLUG_RESET_CYCLES(PLUG_RESET_CYCLES)) u_props (.clk(clk), .reset_n(reset_n),
  .system_reset_n(system_reset_n), .clock_buffer_power_down(clock_buffer_power_down),
  .device_present_n(device_present_n), .buffer_refclk_in_pos(buffer_refclk_in_pos),
  .buffer_refclk_in_neg(buffer_refclk_in_neg), .tx_port_data(tx_port_data),
  .buffered_refclk_out_pos(buffered_refclk_out_pos), .buffered_refclk_out_neg(buffered_refclk_out_neg),
  .clock_buffer_enabled(clock_buffer_enabled), .tx_lane_pos(tx_lane_pos), .tx_lane_neg(tx_lane_neg),
  .downstream_reset_n(downstream_reset_n), .sticky_plug_seen(sticky_plug_seen));

// ---- verif/src_platform_model.sv ----
// platform oscillator feeding the clock buffer input pair
`timescale 1ns/1ps
module src_platform_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench control
  input wire logic run,
  // differential pair
  output logic refclk_pos,
  output logic refclk_neg
);
  // holds its level while stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refclk_pos <= 1'b0;
    end else if (run) begin
      refclk_pos <= !refclk_pos;
    end
  end
  assign refclk_neg = !refclk_pos;
endmodule

// ---- verif/test_src_reset_clock_ctrl.sv ----
// self-checking bench for the reset and clock buffer control block
`timescale 1ns/1ps
`define CHK(a, b, m) \
  begin \
    check_count++; \
    if ((a) !== (b)) begin \
      fail_count++; \
      $display("MISMATCH %0t %s", $time, m); \
    end \
  end
module test_src_reset_clock_ctrl;
  localparam logic [src_pkg::PLUG_CNT_W-1:0] PLUG = 22'h000008;
  logic clk, reset_n, system_reset_n, clock_buffer_power_down, run, buffer_refclk_in_pos, buffer_refclk_in_neg;
  logic clock_buffer_enabled;
  logic [2:1] device_present_n, downstream_reset_n, sticky_plug_seen;
  logic [2:0] buffered_refclk_out_pos, buffered_refclk_out_neg;
  logic [3:0] tx_lane_pos, tx_lane_neg;
  src_pkg::src_tx_ports_t tx_port_data;
  int fail_count, check_count;
  src_reset_clock_ctrl #(.PLUG_RESET_CYCLES(PLUG)) uut (.clk(clk), .reset_n(reset_n), .system_reset_n(system_reset_n),
    .clock_buffer_power_down(clock_buffer_power_down), .device_present_n(device_present_n),
    .buffer_refclk_in_pos(buffer_refclk_in_pos), .buffer_refclk_in_neg(buffer_refclk_in_neg),
    .buffered_refclk_out_pos(buffered_refclk_out_pos), .buffered_refclk_out_neg(buffered_refclk_out_neg),
    .clock_buffer_enabled(clock_buffer_enabled), .tx_port_data(tx_port_data), .tx_lane_pos(tx_lane_pos),
    .tx_lane_neg(tx_lane_neg), .downstream_reset_n(downstream_reset_n), .sticky_plug_seen(sticky_plug_seen));
  src_platform_model u_ref (.clk(clk), .reset_n(reset_n), .run(run), .refclk_pos(buffer_refclk_in_pos),
    .refclk_neg(buffer_refclk_in_neg));
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_boot();
    settle(5);
    `CHK(downstream_reset_n, 2'h0, "resets not held")
    `CHK(tx_lane_pos, 4'h0, "lanes not idle")
    @(posedge clk);
    system_reset_n <= 1'b1;
    settle(5);
    `CHK(downstream_reset_n, 2'h3, "empty ports held")
  endtask
  task automatic t_lanes();
    logic [7:0] pats [4] = '{8'h5A, 8'hA5, 8'h0F, 8'hC3};
    src_pkg::src_tx_ports_t d;
    for (int i = 0; i < 4; i++) begin
      d = pats[i];
      @(posedge clk);
      tx_port_data <= d;
      settle(1);
      `CHK(tx_lane_pos, {d.up1.pos, d.dn2.pos, d.dn1.pos, d.up0.pos}, "lane pos")
      `CHK(tx_lane_neg, {d.up1.neg, d.dn2.neg, d.dn1.neg, d.up0.neg}, "lane neg")
    end
  endtask
  task automatic t_plug(input int x);
    int n;
    @(posedge clk);
    device_present_n[x] <= 1'b0;
    n = 0;
    settle(1);
    while (downstream_reset_n[x] !== 1'b0 && n < 8) begin
      settle(1);
      n++;
    end
    `CHK(n < 4, 1'b1, "plug reset late")
    `CHK(sticky_plug_seen[x], 1'b1, "flag not set")
    `CHK(downstream_reset_n[3-x], 1'b1, "wrong port reset")
    n = 0;
    while (downstream_reset_n[x] === 1'b0 && n < 50) begin
      settle(1);
      n++;
    end
    `CHK(n, int'(PLUG), "hold length")
  endtask
  task automatic t_sysrst_sticky();
    @(posedge clk);
    system_reset_n <= 1'b0;
    settle(5);
    `CHK(downstream_reset_n, 2'h0, "resets not held")
    `CHK(sticky_plug_seen, 2'h3, "sticky cleared")
    @(posedge clk);
    system_reset_n <= 1'b1;
    settle(5);
    `CHK(downstream_reset_n, 2'h3, "extra reset")
  endtask
  task automatic t_unplug();
    @(posedge clk);
    device_present_n[1] <= 1'b1;
    settle(5);
    `CHK(downstream_reset_n, 2'h3, "reset on unplug")
    @(posedge clk);
    device_present_n[1] <= 1'b0;
    settle(4);
    `CHK(downstream_reset_n, 2'h2, "replug reset missing")
    @(posedge clk);
    device_present_n[1] <= 1'b1;
    settle(4);
    `CHK(downstream_reset_n, 2'h3, "unplug kept reset")
  endtask
  task automatic t_clkbuf();
    @(posedge clk);
    clock_buffer_power_down <= 1'b1;
    run <= 1'b1;
    settle(5);
    `CHK({clock_buffer_enabled, buffered_refclk_out_pos, buffered_refclk_out_neg}, 7'h00, "buffer on")
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      clock_buffer_power_down <= 1'b0;
      run <= 1'b1;
      repeat (i + 3) @(posedge clk);
      run <= 1'b0;
      settle(5);
      `CHK(clock_buffer_enabled, 1'b1, "buffer off")
      `CHK(buffered_refclk_out_pos, {3{buffer_refclk_in_pos}}, "refclk pos")
      `CHK(buffered_refclk_out_neg, {3{buffer_refclk_in_neg}}, "refclk neg")
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    fail_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    system_reset_n = 1'b0;
    clock_buffer_power_down = 1'b0;
    device_present_n = 2'h3;
    tx_port_data = '0;
    run = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_boot();
    t_lanes();
    t_plug(1);
    t_plug(2);
    t_sysrst_sticky();
    t_unplug();
    t_clkbuf();
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
